// ---- mzc_carrier_model.sv ----
`timescale 1ns/1ps
module mzc_carrier_model (
   input wire logic sys_clk, // bus clock
   input wire logic resetn, // bus reset
   input wire logic reqN, // agent request
   input wire logic slow, // late grant
   input wire logic [3:0] intOe, // card pulls lines low
   input wire logic [3:0] extInt, // other cards pulling
   input wire logic capOe, // card pulls capability low
   input wire logic slowDev, // slow-only device present
   output logic grantN, // arbiter grant
   output logic [3:0] intLevel, // wired lines
   output logic capLevel // wired capability line
);
   logic [2:0] wait_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wait_r <= 3'h0;
         grantN <= 1'b1;
      end else if (reqN) begin
         wait_r <= 3'h0;
         grantN <= 1'b1;
      end else if (wait_r >= (slow ? 3'h4 : 3'h1)) begin
         grantN <= 1'b0;
      end else begin
         wait_r <= wait_r + 3'h1;
      end
   end
   // carrier pull-ups, so a released line reads high
   assign intLevel = ~(intOe | extInt);
   assign capLevel = ~(capOe | slowDev);
endmodule // mzc_carrier_model

// ---- mzc_role_params.svh ----
`ifndef MZC_ROLE_PARAMS_SVH
`define MZC_ROLE_PARAMS_SVH
// register byte offsets
`define MZC_OFS_INFO 12'h000
`define MZC_OFS_CTRL 12'h004
`define MZC_OFS_LOCAL 12'h008
`define MZC_OFS_STATUS 12'h00C
`define MZC_OFS_MASK 12'h010
// control fields
`define MZC_CTRL_LISTEN_LSB 0
`define MZC_CTRL_SLOW 4
`define MZC_CTRL_REQ 5
// reset values
`define MZC_CTRL_RST 6'h0F
`define MZC_LOCAL_RST 4'h0
`define MZC_MASK_RST 7'h00
`endif

// ---- mzc_role_pkg.sv ----
package mzc_role_pkg;
   typedef enum {CAPT_IDLE, CAPT_SETTLE, CAPT_SAMPLE, CAPT_LOCKED} mzc_capt_t;
   typedef struct packed {
      logic fastLow;
      logic cfgHit;
      logic grant;
      logic [3:0] line;
   } mzc_evt_t;
   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } mzc_odpin_t;
endpackage

// ---- mzc_role_select.sv ----
`timescale 1ns/1ps
`include "mzc_role_params.svh"
module mzc_role_select (
   input wire logic sys_clk, // pci-derived clock
   input wire logic resetn, // carrier bus reset
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic pready, // apb ready
   output logic [31:0] prdata, // apb read data
   output logic pslverr, // apb error
   input wire logic roleStrapN, // host-role strap
   input wire logic [3:0] intLineIn, // interrupt lines a..d level
   output mzc_role_pkg::mzc_odpin_t intLines, // interrupt line drive
   input wire logic fastBusCapableIn, // capability line level
   output logic fastBusCapableOut, // capability line drive value
   output logic fastBusCapableOe, // capability line enable
   input wire logic secondAgentCfgSelect, // second agent cfg select
   output logic secondAgentCfgHit, // second agent addressed
   input wire logic [3:0] secondAgentIntReq, // second agent interrupts
   input wire logic secondAgentBusGrantN, // arbiter grant
   output logic secondAgentBusRequestN, // request to arbiter
   output logic secondAgentBusOwned, // agent may drive bus
   output logic presentN, // card presence
   output logic hostRole, // host role in effect
   output logic enumEnable, // enumeration allowed
   output logic busAt33, // bus held to slow speed
   output logic irq // unmasked event pending
);

   function automatic logic [3:0] rotInt(input logic [3:0] a);
      rotInt = {a[2:0], a[3]};
   endfunction

   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (a == `MZC_OFS_INFO) || (a == `MZC_OFS_CTRL) ||
                 (a == `MZC_OFS_LOCAL) || (a == `MZC_OFS_STATUS) ||
                 (a == `MZC_OFS_MASK);
   endfunction

   // strap capture
   logic strapMeta_r, strapSync_r;
   mzc_role_pkg::mzc_capt_t capt_r, capt_nxt;
   logic hostRole_r, hostRole_nxt;

   always_comb begin
      capt_nxt = capt_r;
      hostRole_nxt = hostRole_r;
      case (capt_r)
         mzc_role_pkg::CAPT_IDLE: capt_nxt = mzc_role_pkg::CAPT_SETTLE;
         mzc_role_pkg::CAPT_SETTLE: capt_nxt = mzc_role_pkg::CAPT_SAMPLE;
         mzc_role_pkg::CAPT_SAMPLE: begin
            hostRole_nxt = ~strapSync_r;
            capt_nxt = mzc_role_pkg::CAPT_LOCKED;
         end
         mzc_role_pkg::CAPT_LOCKED: capt_nxt = mzc_role_pkg::CAPT_LOCKED;
         default: capt_nxt = mzc_role_pkg::CAPT_IDLE;
      endcase
   end

   // reset holds plain i/o role: interrupt lines not driven until the strap is known
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         strapMeta_r <= 1'b1;
         strapSync_r <= 1'b1;
         capt_r <= mzc_role_pkg::CAPT_IDLE;
         hostRole_r <= 1'b0;
      end else begin
         strapMeta_r <= roleStrapN;
         strapSync_r <= strapMeta_r;
         capt_r <= capt_nxt;
         hostRole_r <= hostRole_nxt;
      end
   end

   wire locked = (capt_r == mzc_role_pkg::CAPT_LOCKED);

   // apb slave and registers
   logic [5:0] ctrl_r, ctrl_nxt;
   logic [3:0] local_r, local_nxt;
   logic [6:0] mask_r, mask_nxt;
   mzc_role_pkg::mzc_evt_t status_r, status_nxt, evt;
   logic [31:0] prdata_nxt;
   logic pready_nxt, pslverr_nxt;
   logic [3:0] linePrev_r;
   logic cfgPrev_r, fastPrev_r, owned_r, owned_nxt;

   wire setup = psel & ~penable;
   wire done = psel & penable & pready;
   wire wrDone = done & pwrite & isMapped(paddr);
   wire rdStat = done & ~pwrite & (paddr == `MZC_OFS_STATUS);
   wire [3:0] listen = ctrl_r[`MZC_CTRL_LISTEN_LSB +: 4];

   always_comb begin
      evt = '0;
      // software may repartition via listen bits; hardware never does
      if (hostRole_r && locked) begin
         evt.line = linePrev_r & ~intLineIn & listen;
      end
      evt.grant = owned_nxt & ~owned_r;
      evt.cfgHit = secondAgentCfgSelect & ~cfgPrev_r;
      evt.fastLow = fastPrev_r & ~fastBusCapableIn;
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      local_nxt = local_r;
      mask_nxt = mask_r;
      if (wrDone && paddr == `MZC_OFS_CTRL) ctrl_nxt = pwdata[5:0];
      if (wrDone && paddr == `MZC_OFS_LOCAL) local_nxt = pwdata[3:0];
      if (wrDone && paddr == `MZC_OFS_MASK) mask_nxt = pwdata[6:0];
      // set beats the read-clear in the same cycle
      status_nxt = (rdStat ? 7'h00 : status_r) | evt;
      pready_nxt = setup;
      pslverr_nxt = setup & ~isMapped(paddr);
      prdata_nxt = prdata;
      if (setup) begin
         prdata_nxt = 32'h0000_0000;
         case (paddr)
            `MZC_OFS_INFO: prdata_nxt[4:0] = {owned_r, busAt33,
               locked, enumEnable, hostRole_r};
            `MZC_OFS_CTRL: prdata_nxt[5:0] = ctrl_r;
            `MZC_OFS_LOCAL: prdata_nxt[3:0] = local_r;
            `MZC_OFS_STATUS: prdata_nxt[6:0] = status_r;
            `MZC_OFS_MASK: prdata_nxt[6:0] = mask_r;
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      owned_nxt = ctrl_r[`MZC_CTRL_REQ] & ~secondAgentBusGrantN;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= `MZC_CTRL_RST;
         local_r <= `MZC_LOCAL_RST;
         mask_r <= `MZC_MASK_RST;
         status_r <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         linePrev_r <= 4'hF;
         cfgPrev_r <= 1'b0;
         fastPrev_r <= 1'b1;
         owned_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         local_r <= local_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         prdata <= prdata_nxt;
         linePrev_r <= intLineIn;
         cfgPrev_r <= secondAgentCfgSelect;
         fastPrev_r <= fastBusCapableIn;
         owned_r <= owned_nxt;
      end
   end

   // pin outputs
   mzc_role_pkg::mzc_odpin_t pins_nxt;
   always_comb begin
      pins_nxt.o = 4'h0;
      // host never drives; i/o role pulls own plus rotated agent requests
      if (hostRole_r || !locked) pins_nxt.oe = 4'h0;
      else pins_nxt.oe = local_r | rotInt(secondAgentIntReq);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         intLines <= '0;
         fastBusCapableOut <= 1'b0;
         fastBusCapableOe <= 1'b0;
         secondAgentCfgHit <= 1'b0;
         secondAgentBusRequestN <= 1'b1;
         secondAgentBusOwned <= 1'b0;
         presentN <= 1'b0;
         hostRole <= 1'b0;
         enumEnable <= 1'b0;
         busAt33 <= 1'b0;
         irq <= 1'b0;
      end else begin
         intLines <= pins_nxt;
         fastBusCapableOut <= 1'b0;
         fastBusCapableOe <= ctrl_r[`MZC_CTRL_SLOW];
         secondAgentCfgHit <= secondAgentCfgSelect;
         secondAgentBusRequestN <= ~ctrl_r[`MZC_CTRL_REQ];
         secondAgentBusOwned <= owned_r;
         presentN <= 1'b0;
         hostRole <= hostRole_r;
         enumEnable <= hostRole_r & locked;
         busAt33 <= ~fastBusCapableIn;
         irq <= |(status_r & mask_r);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_present_low: assert property (
      presentN == 1'b0)
      else $error("presence output not low");
   a_host_no_drive: assert property (
      hostRole_r |=> intLines.oe == 4'h0)
      else $error("host role drives interrupt line");
   a_io_drive: assert property (
      locked && !hostRole_r && local_r[2] |=> intLines.oe[2])
      else $error("own interrupt not driven");
   a_rotate_map: assert property (
      locked && !hostRole_r && local_r == 4'h0
      |=> intLines.oe == rotInt($past(secondAgentIntReq)))
      else $error("second agent interrupt mapping wrong");
   a_line_detect: assert property (
      hostRole_r && locked && listen[1] && linePrev_r[1]
      && !intLineIn[1] |=> status_r.line[1])
      else $error("line assertion not reported");
   a_role_held: assert property (
      locked |=> $stable(hostRole_r) && locked)
      else $error("role changed after capture");
   a_capture: assert property (
      capt_r == mzc_role_pkg::CAPT_SAMPLE |=> hostRole_r ==
      !$past(strapSync_r) ##1 enumEnable == hostRole_r)
      else $error("strap not captured");
   a_fast_no_high: assert property (
      !fastBusCapableOut)
      else $error("capability line driven high");
   a_slow_bus: assert property (
      !fastBusCapableIn |=> busAt33)
      else $error("slow bus not flagged");
   // request may be withdrawn right after grant, so ownership is checked for one cycle only
   a_req_grant: assert property (
      ctrl_r[`MZC_CTRL_REQ] && !secondAgentBusGrantN
      |=> !secondAgentBusRequestN ##1 secondAgentBusOwned)
      else $error("request or ownership missing");
   a_no_grant_own: assert property (
      secondAgentBusGrantN |=> !owned_r)
      else $error("bus owned without grant");
   a_cfg_sel: assert property (
      secondAgentCfgSelect |=> secondAgentCfgHit)
      else $error("config select not followed");
   a_reset_role: assert property (
      $rose(locked) |-> $past(capt_r) == mzc_role_pkg::CAPT_SAMPLE)
      else $error("role locked out of order");
   a_cfg_idle: assert property (
      !secondAgentCfgSelect |=> !secondAgentCfgHit)
      else $error("config hit without select");
   a_req_idle: assert property (
      !ctrl_r[`MZC_CTRL_REQ] |=> secondAgentBusRequestN)
      else $error("request without control bit");
   a_cap_pull: assert property (
      ctrl_r[`MZC_CTRL_SLOW] |=> fastBusCapableOe)
      else $error("capability line not pulled low");
   a_fast_bus: assert property (
      fastBusCapableIn |=> !busAt33)
      else $error("slow bus flagged on fast bus");
   a_host_enum: assert property (
      hostRole_r && locked |=> enumEnable)
      else $error("host role without enumeration");
   a_io_no_enum: assert property (
      !hostRole_r |=> !enumEnable)
      else $error("enumeration in plain role");
   a_lock_no_drive: assert property (
      !locked |=> intLines.oe == 4'h0)
      else $error("line driven before role known");
   a_io_no_event: assert property (
      !hostRole_r |-> evt.line == 4'h0)
      else $error("line event in plain role");
   a_set_wins: assert property (
      rdStat && evt.line[0] |=> status_r.line[0])
      else $error("read clear beat new event");
   a_irq_level: assert property (
      |(status_r & mask_r) |=> irq)
      else $error("interrupt not raised");
   a_irq_quiet: assert property (
      !(|(status_r & mask_r)) |=> !irq)
      else $error("interrupt without pending event");
   a_ready_pulse: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("ready not a single access cycle");
   a_err_unmapped: assert property (
      psel && !penable && !isMapped(paddr) |=> pslverr)
      else $error("unmapped access not flagged");

   c_host_event: cover property (hostRole_r && |status_r.line);
   c_io_drive: cover property (!hostRole_r && locked && |intLines.oe);
   c_grant: cover property (status_r.grant && irq);
   c_err: cover property (pslverr && pready);
   c_slow_bus: cover property (busAt33 && fastBusCapableOe);
endmodule // mzc_role_select

// ---- tb_mzc_role_select.sv ----
`timescale 1ns/1ps
`include "mzc_role_params.svh"
module tb_mzc_role_select;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic roleStrapN = 1'b1;
   logic cfgSel = 1'b0;
   logic slow = 1'b0;
   logic slowDev = 1'b0;
   logic [3:0] extInt = 4'h0;
   logic [3:0] agentInt = 4'h0;
   logic [3:0] intLevel, loc, ag;
   logic pready, pslverr, hostRole, enumEnable, busAt33, irq, presentN;
   logic grantN, capLevel, capOut, capOe, cfgHit, reqN, owned;
   mzc_role_pkg::mzc_odpin_t intLines;
   logic [32:0] expQ [$];
   int failures = 0;
   int comparisons = 0;

   always #2.5 sys_clk = ~sys_clk;

   mzc_role_select dut (.sys_clk(sys_clk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .roleStrapN(roleStrapN), .intLineIn(intLevel),
      .intLines(intLines), .fastBusCapableIn(capLevel),
      .fastBusCapableOut(capOut), .fastBusCapableOe(capOe),
      .secondAgentCfgSelect(cfgSel), .secondAgentCfgHit(cfgHit),
      .secondAgentIntReq(agentInt), .secondAgentBusGrantN(grantN),
      .secondAgentBusRequestN(reqN), .secondAgentBusOwned(owned),
      .presentN(presentN), .hostRole(hostRole), .enumEnable(enumEnable),
      .busAt33(busAt33), .irq(irq));

   mzc_carrier_model carrier (.sys_clk(sys_clk), .resetn(resetn),
      .reqN(reqN), .slow(slow), .intOe(intLines.oe), .extInt(extInt),
      .capOe(capOe), .slowDev(slowDev), .grantN(grantN),
      .intLevel(intLevel), .capLevel(capLevel));

   task automatic chk(input string n, input logic [32:0] e,
         input logic [32:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [32:0] e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      if (!w) expQ.push_back(e);
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read data judged at the edge that completes the access
   always @(posedge sys_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0)
         chk("prdata", expQ.pop_front(), {pslverr, prdata});
   end

   task automatic rst(input logic s);
      roleStrapN <= s;
      resetn <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk("presentN", 33'h0, 33'(presentN));
      chk("rstHost", 33'h0, 33'(hostRole));
      chk("rstOe", 33'h0, 33'(intLines.oe));
      resetn <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      finish_test();
   end

   initial begin
      void'($urandom(89384));
      rst(1'b0);
      chk("hostRole", 33'h1, 33'(hostRole));
      chk("enumEnable", 33'h1, 33'(enumEnable));
      apb(1'b0, `MZC_OFS_INFO, 32'h0, 33'h7);
      apb(1'b0, 12'h014, 32'h0, 33'h1_0000_0000);
      extInt <= 4'h2;
      apb(1'b1, `MZC_OFS_MASK, 32'h2, 33'h0);
      repeat (3) @(posedge sys_clk);
      chk("intOe", 33'h0, 33'(intLines.oe));
      chk("irq", 33'h1, 33'(irq));
      apb(1'b0, `MZC_OFS_STATUS, 32'h0, 33'h2);
      apb(1'b0, `MZC_OFS_STATUS, 32'h0, 33'h0);
      extInt <= 4'h0;
      roleStrapN <= 1'b1;
      apb(1'b1, `MZC_OFS_CTRL, 32'h0, 33'h0);
      extInt <= 4'h4;
      slowDev <= 1'b1;
      apb(1'b1, `MZC_OFS_CTRL, 32'h10, 33'h0);
      repeat (3) @(posedge sys_clk);
      chk("irqClr", 33'h0, 33'(irq));
      chk("hostHeld", 33'h1, 33'(hostRole));
      chk("busAt33", 33'h1, 33'(busAt33));
      chk("capOe", 33'h1, 33'(capOe));
      chk("capOut", 33'h0, 33'(capOut));
      apb(1'b0, `MZC_OFS_STATUS, 32'h0, 33'h40);
      $display("test host done");
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         cfgSel <= 1'b1;
         apb(1'b1, `MZC_OFS_CTRL, 32'h30, 33'h0);
         repeat (10) @(posedge sys_clk);
         chk("reqN", 33'h0, 33'(reqN));
         chk("owned", 33'h1, 33'(owned));
         chk("cfgHit", 33'h1, 33'(cfgHit));
         apb(1'b0, `MZC_OFS_STATUS, 32'h0, 33'h30);
         apb(1'b0, `MZC_OFS_INFO, 32'h0, 33'h1F);
         cfgSel <= 1'b0;
         apb(1'b1, `MZC_OFS_CTRL, 32'h10, 33'h0);
         repeat (4) @(posedge sys_clk);
         chk("ownedOff", 33'h0, 33'(owned));
         chk("reqOff", 33'h1, 33'(reqN));
      end
      $display("test agent done");
      slowDev <= 1'b0;
      extInt <= 4'h0;
      rst(1'b1);
      chk("ioRole", 33'h0, 33'(hostRole));
      chk("ioEnum", 33'h0, 33'(enumEnable));
      apb(1'b0, `MZC_OFS_INFO, 32'h0, 33'h4);
      for (int i = 0; i < 8; i++) begin
         loc = 4'($urandom());
         ag = 4'($urandom());
         agentInt <= ag;
         apb(1'b1, `MZC_OFS_LOCAL, 32'(loc), 33'h0);
         repeat (3) @(posedge sys_clk);
         chk("ioOe", 33'(loc | {ag[2:0], ag[3]}), 33'(intLines.oe));
         chk("ioO", 33'h0, 33'(intLines.o));
      end
      roleStrapN <= 1'b0;
      apb(1'b0, `MZC_OFS_STATUS, 32'h0, 33'h0);
      chk("ioHeld", 33'h0, 33'(hostRole));
      $display("test io done");
      finish_test();
   end
endmodule // tb_mzc_role_select
